/* rtl/cis_core_instruction_subset.sv */
// execution unit for bit clear, negative branch, halt and subtract with borrow
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cis_core_instruction_subset
  import cis_pkg::*;
#(
  parameter int WDOG_WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_event,
  output logic halted
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] file_reg;
    logic [7:0] acc;
    logic [7:0] status;
    logic [20:0] pc;
    logic [WDOG_WIDTH-1:0] wdog;
    logic [7:0] postscale;
    cis_state_type state;
    logic wake_s1;
    logic wake_s2;
    logic awready;
    logic wready;
    logic arready;
    logic halted;
  } cis_regs_type;

  cis_regs_type r_q;
  cis_regs_type r_d;
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic [7:0] res;
  logic [15:0] ins;

  // ==========================================================
  // next state: bus slave plus instruction execution
  always_comb begin
    r_d = r_q;
    ins = r_q.w_data[15:0];
    // wake pin synchroniser
    r_d.wake_s1 = wake_event;
    r_d.wake_s2 = r_q.wake_s1;
    // subtract datapath: borrow in is inverted carry
    diff = {1'b0, r_q.acc} - {1'b0, r_q.file_reg} - {8'h00, ~r_q.status[CIS_ST_C]};
    ldiff = {1'b0, r_q.acc[3:0]} - {1'b0, r_q.file_reg[3:0]} - {4'h0, ~r_q.status[CIS_ST_C]};
    res = diff[7:0];
    // watchdog runs while not halted
    if (r_q.state != CIS_HALTED) begin
      r_d.wdog = r_q.wdog + 1'b1;
      if (&r_q.wdog) begin
        r_d.postscale = r_q.postscale + 8'h01;
      end
    end
    // two-cycle branch second slot
    if (r_q.state == CIS_BRANCH_WAIT) begin
      r_d.state = CIS_RUN;
    end
    // leave halt on synchronised wake
    if (r_q.state == CIS_HALTED && r_q.wake_s2) begin
      r_d.state = CIS_RUN;
    end
    // write address and data taken in either order
    if (s_axi_awvalid && !r_q.aw_got && !r_q.bvalid) begin
      r_d.aw_got = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_q.w_got && !r_q.bvalid) begin
      r_d.w_got = 1'b1;
      r_d.w_data = s_axi_wdata;
      r_d.w_strb = s_axi_wstrb;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (r_q.aw_got && r_q.w_got) begin
      r_d.aw_got = 1'b0;
      r_d.w_got = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = CIS_RESP_OKAY;
      if (r_q.aw_addr == CIS_ADDR_INSTR) begin
        if (r_q.state != CIS_RUN) begin
          r_d.bresp = CIS_RESP_SLVERR; // busy: branch slot or halted
        end else if (ins[15:12] == CIS_OP_BIT_CLEAR) begin
          r_d.file_reg[ins[11:9]] = 1'b0;
          r_d.pc = r_q.pc + 21'h000002;
        end else if (ins[15:8] == CIS_OP_BRANCH_NEG) begin
          // taken branch adds 2 plus 2n
          if (r_q.status[CIS_ST_N]) begin
            r_d.pc = r_q.pc + 21'h000002 + {{12{ins[7]}}, ins[7:0], 1'b0};
            r_d.state = CIS_BRANCH_WAIT;
          end else begin
            r_d.pc = r_q.pc + 21'h000002;
          end
        end else if (ins == CIS_OP_HALT) begin
          // clear watchdog and postscaler, set timeout
          r_d.wdog = '0;
          r_d.postscale = 8'h00;
          r_d.status[CIS_ST_TO] = 1'b1;
          r_d.status[CIS_ST_PD] = 1'b0;
          r_d.state = CIS_HALTED;
          r_d.pc = r_q.pc + 21'h000002;
        end else if (ins[15:10] == CIS_OP_SUB_BORROW) begin
          if (ins[9]) begin
            r_d.file_reg = res;
          end else begin
            r_d.acc = res;
          end
          // flags from result, carry is not-borrow
          r_d.status[CIS_ST_C] = ~diff[8];
          r_d.status[CIS_ST_DC] = ~ldiff[4];
          r_d.status[CIS_ST_Z] = (res == 8'h00);
          r_d.status[CIS_ST_N] = res[7];
          r_d.status[CIS_ST_OV] = (r_q.acc[7] != r_q.file_reg[7]) && (res[7] != r_q.acc[7]);
          r_d.pc = r_q.pc + 21'h000002;
        end else begin
          r_d.bresp = CIS_RESP_SLVERR; // unsupported opcode
        end
      end else if (r_q.aw_addr == CIS_ADDR_FILE) begin
        if (r_q.w_strb[0]) r_d.file_reg = r_q.w_data[7:0];
      end else if (r_q.aw_addr == CIS_ADDR_ACC) begin
        if (r_q.w_strb[0]) r_d.acc = r_q.w_data[7:0];
      end else if (r_q.aw_addr == CIS_ADDR_STATUS) begin
        if (r_q.w_strb[0]) r_d.status[4:0] = r_q.w_data[4:0];
      end else if (r_q.aw_addr == CIS_ADDR_PC) begin
        if (&r_q.w_strb[2:0]) r_d.pc = r_q.w_data[20:0];
      end else if (r_q.aw_addr == CIS_ADDR_WAKE || r_q.aw_addr == CIS_ADDR_WDOG) begin
        r_d.bresp = CIS_RESP_OKAY; // read-only, write ignored
      end else begin
        r_d.bresp = CIS_RESP_DECERR;
      end
    end
    // read channel: one-cycle answer
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r_q.rvalid) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = CIS_RESP_OKAY;
      r_d.rdata = 32'h00000000;
      if (s_axi_araddr == CIS_ADDR_INSTR) begin
        r_d.rdata = {16'h0000, r_q.w_data[15:0]};
      end else if (s_axi_araddr == CIS_ADDR_FILE) begin
        r_d.rdata = {24'h000000, r_q.file_reg};
      end else if (s_axi_araddr == CIS_ADDR_ACC) begin
        r_d.rdata = {24'h000000, r_q.acc};
      end else if (s_axi_araddr == CIS_ADDR_STATUS) begin
        r_d.rdata = {24'h000000, r_q.state == CIS_HALTED, r_q.status[6:0]};
      end else if (s_axi_araddr == CIS_ADDR_PC) begin
        r_d.rdata = {11'h000, r_q.pc};
      end else if (s_axi_araddr == CIS_ADDR_WAKE) begin
        r_d.rdata = {31'h00000000, r_q.wake_s2};
      end else if (s_axi_araddr == CIS_ADDR_WDOG) begin
        r_d.rdata = 32'({r_q.postscale, r_q.wdog});
      end else begin
        r_d.rresp = CIS_RESP_DECERR;
      end
    end
    // ready and halt outputs taken from the next state, so each pin is a flop
    // with the same timing as the combinational form it replaces
    r_d.awready = !r_d.aw_got && !r_d.bvalid;
    r_d.wready = !r_d.w_got && !r_d.bvalid;
    r_d.arready = !r_d.rvalid;
    r_d.halted = (r_d.state == CIS_HALTED);
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
      r_q.status <= CIS_STATUS_RST;
      r_q.pc <= CIS_PC_RST;
      r_q.state <= CIS_RUN;
      r_q.awready <= 1'b1; // idle slave accepts at once
      r_q.wready <= 1'b1;
      r_q.arready <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign s_axi_awready = r_q.awready;
  assign s_axi_wready = r_q.wready;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = r_q.arready;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;
  assign halted = r_q.halted;

endmodule // cis_core_instruction_subset
`default_nettype wire

/* rtl/cis_pkg.sv */
// constants and types for the core instruction subset block
//
// Notes on behaviour
// - bit clear zeroes bit b, flags kept
// - negative branch: pc plus two plus 2n
// - halt clears watchdog, postscaler; sets timeout flag
// - halt clears powerdown flag, waits for wake
// - subtract acc minus reg minus inverted carry
package cis_pkg;
  // ==========================================================
  // opcode encodings (upper bits of the 16-bit instruction word; halt is the whole word)
  localparam logic [3:0] CIS_OP_BIT_CLEAR = 4'h9;
  localparam logic [7:0] CIS_OP_BRANCH_NEG = 8'hE6;
  localparam logic [15:0] CIS_OP_HALT = 16'h0003;
  localparam logic [5:0] CIS_OP_SUB_BORROW = 6'h15;
  // ==========================================================
  // axi4-lite register byte addresses
  localparam logic [7:0] CIS_ADDR_INSTR = 8'h00;
  localparam logic [7:0] CIS_ADDR_FILE = 8'h04;
  localparam logic [7:0] CIS_ADDR_ACC = 8'h08;
  localparam logic [7:0] CIS_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] CIS_ADDR_PC = 8'h10;
  localparam logic [7:0] CIS_ADDR_WAKE = 8'h14;
  localparam logic [7:0] CIS_ADDR_WDOG = 8'h18;
  // ==========================================================
  // status field positions
  localparam int CIS_ST_C = 0;
  localparam int CIS_ST_DC = 1;
  localparam int CIS_ST_Z = 2;
  localparam int CIS_ST_OV = 3;
  localparam int CIS_ST_N = 4;
  localparam int CIS_ST_PD = 5;
  localparam int CIS_ST_TO = 6;
  localparam int CIS_ST_HALT = 7;
  // ==========================================================
  // reset values and response codes
  localparam logic [7:0] CIS_STATUS_RST = 8'h60;
  localparam logic [20:0] CIS_PC_RST = 21'h000000;
  localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] CIS_RESP_DECERR = 2'h3;
  localparam logic [1:0] CIS_BRANCH_CYCLES = 2'h2;
  // ==========================================================
  typedef enum logic [1:0] {CIS_RUN, CIS_BRANCH_WAIT, CIS_HALTED} cis_state_type;
endpackage : cis_pkg

/* bench/cis_checker.sv */
// port assertions for the core instruction subset block
`timescale 1ns/1ps
`default_nettype none
module cis_checker
  import cis_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic wake_event,
  input wire logic halted
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // halt write taken, read taken while halted
  sequence s_halt_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !halted
      && s_axi_awaddr == CIS_ADDR_INSTR && s_axi_wdata[15:0] == CIS_OP_HALT;
  endsequence
  sequence s_rd_halted(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && halted && s_axi_araddr == a;
  endsequence
  property p_halt_enter; s_halt_wr |-> ##[1:3] halted; endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");
  property p_halt_hold; (halted && !wake_event) [*3] |=> halted; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt unwoken");
  property p_wake_exit; halted && $rose(wake_event) |-> ##[1:5] !halted; endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake ignored");
  property p_halt_flags;
    s_rd_halted(CIS_ADDR_STATUS) |=> s_axi_rvalid && s_axi_rdata[7:5] == 3'h6;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_wdog_clear; s_rd_halted(CIS_ADDR_WDOG) |=> s_axi_rdata == 32'h0; endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not clear");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
endmodule // cis_checker
bind cis_core_instruction_subset cis_checker i_cis_checker (.*);
`default_nettype wire

/* bench/tb_cis_core_instruction_subset.sv */
// self-checking bench for the core instruction subset block
`timescale 1ns/1ps
`default_nettype none
module tb_cis_core_instruction_subset
  import cis_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, wake_event = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, halted;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0, checks_done = 0;
  cis_core_instruction_subset i_cis_core_instruction_subset (.*);
  // 25 MHz clock
  always #20 aclk = ~aclk;
  // ==========================================
  // compare, report, bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) fail_count++;
    if (n >= 40) tally_and_finish();
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) fail_count++;
    if (n >= 40) tally_and_finish();
    chk({30'h0, s_axi_rresp}, {30'h0, e});
    chk(s_axi_rdata, x);
  endtask
  // ==========================================
  // scenarios
  task automatic bit_clear_case();
    wr(CIS_ADDR_FILE, 32'hC7);
    wr(CIS_ADDR_STATUS, 32'h1F);
    wr(CIS_ADDR_INSTR, {16'h0, CIS_OP_BIT_CLEAR, 3'h7, 9'h0});
    rd(CIS_ADDR_FILE, 32'h47);
    rd(CIS_ADDR_STATUS, 32'h7F);
  endtask
  task automatic branch_case();
    logic [7:0] off [3] = '{8'h80, 8'h7F, 8'h80};
    logic [31:0] pc [3] = '{32'h0F02, 32'h1100, 32'h1002};
    for (int i = 0; i < 3; i++) begin
      wr(CIS_ADDR_STATUS, {27'h0, i < 2, 4'h0});
      wr(CIS_ADDR_PC, 32'h1000);
      wr(CIS_ADDR_INSTR, {16'h0, CIS_OP_BRANCH_NEG, off[i]});
      rd(CIS_ADDR_PC, pc[i]);
    end
  endtask
  task automatic sub_case();
    // file, acc, carry in, dest, result, flags n ov z dc c
    logic [30:0] r [4] = '{{8'h03, 8'h02, 2'h3, 8'hFF, 5'h10}, {8'h02, 8'h05, 2'h2, 8'h03, 5'h03},
      {8'h01, 8'h02, 2'h0, 8'h00, 5'h07}, {8'h01, 8'h80, 2'h2, 8'h7F, 5'h09}};
    for (int i = 0; i < 4; i++) begin
      wr(CIS_ADDR_FILE, {24'h0, r[i][30:23]});
      wr(CIS_ADDR_ACC, {24'h0, r[i][22:15]});
      wr(CIS_ADDR_STATUS, {31'h0, r[i][14]});
      wr(CIS_ADDR_INSTR, {16'h0, CIS_OP_SUB_BORROW, r[i][13], 9'h0});
      rd(r[i][13] ? CIS_ADDR_FILE : CIS_ADDR_ACC, {24'h0, r[i][12:5]});
      rd(CIS_ADDR_STATUS, {24'h0, 3'h3, r[i][4:0]});
    end
  endtask
  task automatic halt_case();
    wr(CIS_ADDR_STATUS, 32'h0);
    wr(CIS_ADDR_INSTR, {16'h0, CIS_OP_HALT});
    chk({31'h0, halted}, 32'h1);
    rd(CIS_ADDR_STATUS, 32'hC0);
    rd(CIS_ADDR_WDOG, 32'h0);
    wr(CIS_ADDR_INSTR, {16'h0, CIS_OP_HALT}, CIS_RESP_SLVERR);
    wake_event <= 1'b1;
    for (int n = 0; n < 10 && halted; n++) @(posedge aclk);
    chk({31'h0, halted}, 32'h0);
    if (halted !== 1'b0) tally_and_finish();
    rd(CIS_ADDR_WAKE, 32'h1);
    wake_event <= 1'b0;
    rd(CIS_ADDR_STATUS, 32'h40);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CIS_ADDR_STATUS, 32'h60);
    rd(CIS_ADDR_PC, 32'h0);
    bit_clear_case();
    branch_case();
    sub_case();
    halt_case();
    rd(8'h1C, 32'h0, CIS_RESP_DECERR);
    wr(CIS_ADDR_INSTR, 32'hFFFF, CIS_RESP_SLVERR);
    tally_and_finish();
  end
endmodule // tb_cis_core_instruction_subset
`default_nettype wire
